//--- hdl/twowire_slave_tx_status.sv
// Two-wire slave-send engine with status codes and control registers
`timescale 1ns/100ps
// What this block does
// - Own address read acked: flag, code a8
// - Lost arbitration then read-addressed: code b0
// - Sent byte acked: code b8, wait
// - Sent byte not acked: code c0
// - Last byte acked anyway: code c8
// - Clear with ack off: send last byte
// - Clear with ack on: send, expect ack
// - Leave end states to not-addressed mode
// - Begin request issues START once bus free
// - Flag clear reads idle code f8
// - START or STOP mid-frame is bus error
// - Bus error sets flag, code 00
// - Stop request plus clear recovers, clears stop
// - Recovery releases lines, sends no STOP
// - Codes valid with prescaler bits masked
// - Repeated START keeps the bus owned
// - After last byte ignore master, reads ones
// - Own address upper seven, bit zero general call
module twowire_slave_tx_status (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic master_arb_lost,
  output logic start_issued,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  twi_st_pkg::state_t state_reg;
  logic [7:0] code_reg, data_byte_reg, own_addr_reg, shift_reg;
  logic [7:0] rdata_reg, status_view;
  logic [1:0] presc_reg;
  logic [3:0] bit_cnt_reg;
  logic [5:0] hold_cnt_reg;
  logic interrupt_flag_reg, ack_enable_reg, enable_reg;
  logic begin_condition_request_reg, end_condition_request_reg;
  logic last_reg, arb_reg, ack_bit_reg, bus_busy_reg, gen_reg;
  logic sda_oe_reg, scl_oe_reg, start_issued_reg;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic ctl_wr, flag_clear, in_wait, go_tx, go_end, recover;
  logic illegal, addr_match, addr_hit, addr_done, aack_done;
  logic txack_done, set_flag, tx_code, end_code, gen_go, gen_end;

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  sync2 #(.W(2)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din({scl_in, sda_in}),
    .dout({scl_s, sda_s})
  );

  bus_cond_detect u_cond (
    .clock(clock),
    .rst_n(rst_n),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign ctl_wr = reg_wr && reg_addr == twi_st_pkg::OFS_CONTROL;
  assign flag_clear = ctl_wr && reg_wdata[twi_st_pkg::CTL_FLAG];
  assign in_wait = state_reg == twi_st_pkg::S_WAIT && interrupt_flag_reg;
  assign tx_code = code_reg == twi_st_pkg::ST_OWN_READ ||
    code_reg == twi_st_pkg::ST_ARB_READ ||
    code_reg == twi_st_pkg::ST_DATA_ACK;
  assign end_code = code_reg == twi_st_pkg::ST_DATA_NACK ||
    code_reg == twi_st_pkg::ST_LAST_ACK;
  assign go_tx = in_wait && flag_clear && tx_code;
  assign go_end = in_wait && flag_clear && end_code;
  // Without the stop request the error state simply stays
  assign recover = in_wait && flag_clear &&
    code_reg == twi_st_pkg::ST_BUS_ERROR &&
    reg_wdata[twi_st_pkg::CTL_END];
  assign illegal = (start_det || stop_det) &&
    ((state_reg == twi_st_pkg::S_ADDR && bit_cnt_reg != 4'h0) ||
     state_reg == twi_st_pkg::S_AACK || state_reg == twi_st_pkg::S_TX ||
     state_reg == twi_st_pkg::S_TXACK);
  assign addr_match = shift_reg[7:1] == own_addr_reg[7:1] ||
    (shift_reg[7:1] == twi_st_pkg::GENERAL_CALL_ADDR &&
     own_addr_reg[twi_st_pkg::OWN_GCE]);
  assign addr_done = state_reg == twi_st_pkg::S_ADDR && scl_fall &&
    bit_cnt_reg == twi_st_pkg::BITS_PER_BYTE;
  // Write direction belongs to the receiver engine, not answered here
  assign addr_hit = addr_done && ack_enable_reg && addr_match &&
    shift_reg[0];
  assign aack_done = state_reg == twi_st_pkg::S_AACK && scl_fall;
  assign txack_done = state_reg == twi_st_pkg::S_TXACK && scl_fall;
  assign set_flag = aack_done || txack_done || illegal;
  assign gen_go = state_reg == twi_st_pkg::S_IDLE && enable_reg &&
    begin_condition_request_reg && !bus_busy_reg && !gen_reg;
  assign gen_end = gen_reg && hold_cnt_reg == twi_st_pkg::START_HOLD_LAST;

  // ****************************************************************
  // Bus state machine
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n || !enable_reg) begin
      state_reg <= twi_st_pkg::S_IDLE;
    end else if (illegal) begin
      state_reg <= twi_st_pkg::S_WAIT;
    end else begin
      unique case (state_reg)
        twi_st_pkg::S_IDLE: begin
          // Not addressed: master gets all ones until next START
          if (start_det) state_reg <= twi_st_pkg::S_ADDR;
        end
        twi_st_pkg::S_ADDR: begin
          if (stop_det) state_reg <= twi_st_pkg::S_IDLE;
          else if (addr_hit) state_reg <= twi_st_pkg::S_AACK;
          else if (addr_done) state_reg <= twi_st_pkg::S_IDLE;
        end
        twi_st_pkg::S_AACK: begin
          if (scl_fall) state_reg <= twi_st_pkg::S_WAIT;
        end
        twi_st_pkg::S_WAIT: begin
          if (go_tx) state_reg <= twi_st_pkg::S_TX;
          else if (go_end || recover) state_reg <= twi_st_pkg::S_IDLE;
        end
        twi_st_pkg::S_TX: begin
          if (scl_fall && bit_cnt_reg == twi_st_pkg::LAST_BIT) begin
            state_reg <= twi_st_pkg::S_TXACK;
          end
        end
        twi_st_pkg::S_TXACK: begin
          if (scl_fall) state_reg <= twi_st_pkg::S_WAIT;
        end
      endcase
    end
  end

  // Bit counter and shifter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= twi_st_pkg::DATA_RESET;
    end else if (start_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (go_tx) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= data_byte_reg;
    end else if (state_reg == twi_st_pkg::S_ADDR && scl_rise &&
                 bit_cnt_reg != twi_st_pkg::BITS_PER_BYTE) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg <= {shift_reg[6:0], sda_s};
    end else if (state_reg == twi_st_pkg::S_TX && scl_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg <= {shift_reg[6:0], 1'b1};
    end
  end

  // Acknowledge sampling and last-byte mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_bit_reg <= 1'b1;
      last_reg <= 1'b0;
    end else begin
      if (state_reg == twi_st_pkg::S_TXACK && scl_rise) ack_bit_reg <= sda_s;
      if (go_tx) last_reg <= !reg_wdata[twi_st_pkg::CTL_ACK_EN];
    end
  end

  // Arbitration loss seen by the master engine, kept until decided
  always_ff @(posedge clock) begin
    if (!rst_n) arb_reg <= 1'b0;
    else if (master_arb_lost) arb_reg <= 1'b1;
    else if (aack_done || (addr_done && !addr_hit)) arb_reg <= 1'b0;
  end

  // A repeated START leaves the bus busy; only STOP frees it
  always_ff @(posedge clock) begin
    if (!rst_n) bus_busy_reg <= 1'b0;
    else if (start_det) bus_busy_reg <= 1'b1;
    else if (stop_det) bus_busy_reg <= 1'b0;
  end

  // ****************************************************************
  // Line drivers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n || !enable_reg) begin
      sda_oe_reg <= 1'b0;
    end else if (illegal || recover || aack_done) begin
      sda_oe_reg <= 1'b0;
    end else if (addr_hit) begin
      sda_oe_reg <= 1'b1;
    end else if (go_tx) begin
      sda_oe_reg <= !data_byte_reg[7];
    end else if (state_reg == twi_st_pkg::S_TX && scl_fall) begin
      sda_oe_reg <= bit_cnt_reg != twi_st_pkg::LAST_BIT && !shift_reg[6];
    end else if (gen_go) begin
      sda_oe_reg <= 1'b1;
    end else if (gen_end) begin
      sda_oe_reg <= 1'b0;
    end
  end

  // Stretching trades bus time for software latency
  always_ff @(posedge clock) begin
    if (!rst_n || !enable_reg) scl_oe_reg <= 1'b0;
    else if (aack_done || txack_done) scl_oe_reg <= 1'b1;
    else if (illegal || go_tx || go_end || recover) scl_oe_reg <= 1'b0;
  end

  // START hold timer; bus is handed to the master engine afterwards
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gen_reg <= 1'b0;
      hold_cnt_reg <= 6'h00;
      start_issued_reg <= 1'b0;
    end else begin
      start_issued_reg <= gen_end;
      if (gen_go) begin
        gen_reg <= 1'b1;
        hold_cnt_reg <= 6'h00;
      end else if (gen_end) begin
        gen_reg <= 1'b0;
      end else if (gen_reg) begin
        hold_cnt_reg <= hold_cnt_reg + 6'h01;
      end
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign start_issued = start_issued_reg;

  // ****************************************************************
  // Flag and status code
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) interrupt_flag_reg <= 1'b0;
    else if (set_flag) interrupt_flag_reg <= 1'b1;
    else if (flag_clear) interrupt_flag_reg <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      code_reg <= twi_st_pkg::ST_NO_INFO;
    end else if (illegal) begin
      code_reg <= twi_st_pkg::ST_BUS_ERROR;
    end else if (aack_done) begin
      code_reg <= arb_reg ? twi_st_pkg::ST_ARB_READ :
        twi_st_pkg::ST_OWN_READ;
    end else if (txack_done) begin
      if (ack_bit_reg) code_reg <= twi_st_pkg::ST_DATA_NACK;
      else if (last_reg) code_reg <= twi_st_pkg::ST_LAST_ACK;
      else code_reg <= twi_st_pkg::ST_DATA_ACK;
    end
  end

  // Prescaler bits sit below the code; software masks them
  assign status_view = (interrupt_flag_reg ? code_reg :
    twi_st_pkg::ST_NO_INFO) | {6'h00, presc_reg};

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_enable_reg <= 1'b0;
      enable_reg <= 1'b0;
      begin_condition_request_reg <= 1'b0;
      end_condition_request_reg <= 1'b0;
    end else begin
      if (ctl_wr) begin
        ack_enable_reg <= reg_wdata[twi_st_pkg::CTL_ACK_EN];
        enable_reg <= reg_wdata[twi_st_pkg::CTL_ENABLE];
        begin_condition_request_reg <= reg_wdata[twi_st_pkg::CTL_BEGIN];
      end else if (gen_end) begin
        begin_condition_request_reg <= 1'b0;
      end
      if (recover) end_condition_request_reg <= 1'b0;
      else if (ctl_wr)
        end_condition_request_reg <= reg_wdata[twi_st_pkg::CTL_END];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_byte_reg <= twi_st_pkg::DATA_RESET;
      own_addr_reg <= twi_st_pkg::OWN_ADDR_RESET;
      presc_reg <= twi_st_pkg::PRESC_RESET;
    end else if (reg_wr) begin
      if (reg_addr == twi_st_pkg::OFS_DATA) data_byte_reg <= reg_wdata;
      if (reg_addr == twi_st_pkg::OFS_OWN_ADDR) own_addr_reg <= reg_wdata;
      if (reg_addr == twi_st_pkg::OFS_STATUS) presc_reg <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        twi_st_pkg::OFS_STATUS: rdata_reg <= status_view;
        twi_st_pkg::OFS_DATA: rdata_reg <= data_byte_reg;
        twi_st_pkg::OFS_CONTROL: rdata_reg <= {interrupt_flag_reg,
          ack_enable_reg, begin_condition_request_reg,
          end_condition_request_reg, 1'b0, enable_reg, 2'h0};
        twi_st_pkg::OFS_OWN_ADDR: rdata_reg <= own_addr_reg;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_own_read;
    @(posedge clock) disable iff (!rst_n)
    aack_done && !arb_reg && !illegal |=>
      interrupt_flag_reg && code_reg == twi_st_pkg::ST_OWN_READ;
  endproperty
  a_own_read: assert property (p_own_read)
    else $error("own read address did not give code a8");

  property p_arb_read;
    @(posedge clock) disable iff (!rst_n)
    aack_done && arb_reg && !illegal |=>
      code_reg == twi_st_pkg::ST_ARB_READ && state_reg == twi_st_pkg::S_WAIT;
  endproperty
  a_arb_read: assert property (p_arb_read)
    else $error("arbitration loss read did not give code b0");

  property p_data_ack;
    @(posedge clock) disable iff (!rst_n)
    txack_done && !illegal && !ack_bit_reg && !last_reg |=>
      code_reg == twi_st_pkg::ST_DATA_ACK && scl_oe_reg;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("acked byte did not give code b8");

  property p_data_nack;
    @(posedge clock) disable iff (!rst_n)
    txack_done && !illegal && ack_bit_reg |=>
      code_reg == twi_st_pkg::ST_DATA_NACK;
  endproperty
  a_data_nack: assert property (p_data_nack)
    else $error("nacked byte did not give code c0");

  property p_last_ack;
    @(posedge clock) disable iff (!rst_n)
    txack_done && !illegal && !ack_bit_reg && last_reg |=>
      code_reg == twi_st_pkg::ST_LAST_ACK;
  endproperty
  a_last_ack: assert property (p_last_ack)
    else $error("acked last byte did not give code c8");

  property p_last_mode;
    @(posedge clock) disable iff (!rst_n)
    go_tx && enable_reg && !reg_wdata[twi_st_pkg::CTL_ACK_EN] |=>
      last_reg && state_reg == twi_st_pkg::S_TX;
  endproperty
  a_last_mode: assert property (p_last_mode)
    else $error("clear with ack off did not start last byte");

  property p_more_mode;
    @(posedge clock) disable iff (!rst_n)
    go_tx && reg_wdata[twi_st_pkg::CTL_ACK_EN] |=> !last_reg;
  endproperty
  a_more_mode: assert property (p_more_mode)
    else $error("clear with ack on marked byte as last");

  property p_end_leave;
    @(posedge clock) disable iff (!rst_n)
    go_end |=> state_reg == twi_st_pkg::S_IDLE && !scl_oe_reg;
  endproperty
  a_end_leave: assert property (p_end_leave)
    else $error("end state clear did not reach not-addressed mode");

  property p_idle_code;
    @(posedge clock) disable iff (!rst_n)
    reg_rd && reg_addr == twi_st_pkg::OFS_STATUS && !interrupt_flag_reg |=>
      (reg_rdata & ~8'h03) == twi_st_pkg::ST_NO_INFO;
  endproperty
  a_idle_code: assert property (p_idle_code)
    else $error("status did not read f8 with flag clear");

  property p_bus_error;
    @(posedge clock) disable iff (!rst_n)
    illegal && enable_reg |=> interrupt_flag_reg &&
      code_reg == twi_st_pkg::ST_BUS_ERROR ##1 !sda_oe_reg && !scl_oe_reg;
  endproperty
  a_bus_error: assert property (p_bus_error)
    else $error("bus error did not set flag and release lines");

  property p_recover;
    @(posedge clock) disable iff (!rst_n)
    recover && enable_reg |=> state_reg == twi_st_pkg::S_IDLE &&
      !end_condition_request_reg && !interrupt_flag_reg;
  endproperty
  a_recover: assert property (p_recover)
    else $error("bus error recovery did not complete");

  property p_stretch;
    @(posedge clock) disable iff (!rst_n)
    state_reg == twi_st_pkg::S_WAIT && interrupt_flag_reg &&
      code_reg != twi_st_pkg::ST_BUS_ERROR |-> scl_oe_reg;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock not held while flag set");

endmodule : twowire_slave_tx_status

//--- include/twi_st_pkg.sv
// Constants and types shared by the slave-send status block
package twi_st_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned START_HOLD_NS = 4000;
  localparam int unsigned START_HOLD_CYC =
    (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] START_HOLD_LAST = 6'(START_HOLD_CYC - 1);

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [1:0] OFS_STATUS = 2'h0;
  localparam logic [1:0] OFS_DATA = 2'h1;
  localparam logic [1:0] OFS_CONTROL = 2'h2;
  localparam logic [1:0] OFS_OWN_ADDR = 2'h3;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK_EN = 6;
  localparam int CTL_BEGIN = 5;
  localparam int CTL_END = 4;
  localparam int CTL_ENABLE = 2;
  localparam int OWN_GCE = 0;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
  localparam logic [1:0] PRESC_RESET = 2'h0;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ****************************************************************
  // Status codes
  // ****************************************************************
  localparam logic [7:0] ST_OWN_READ = 8'ha8;
  localparam logic [7:0] ST_ARB_READ = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK = 8'hc8;
  localparam logic [7:0] ST_NO_INFO = 8'hf8;
  localparam logic [7:0] ST_BUS_ERROR = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_WAIT, S_TX, S_TXACK
  } state_t;

endpackage : twi_st_pkg

//--- hdl/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= '1;
      dout <= '1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule : sync2

//--- hdl/bus_cond_detect.sv
// Edge and START/STOP detection on synchronised bus lines
`timescale 1ns/100ps
module bus_cond_detect (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);

  logic scl_d_reg;
  logic sda_d_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  // Data may only move while the clock is low, else it is a condition
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

endmodule : bus_cond_detect

//--- verif/bus_master_model.sv
// Behavioural bus master receiver on the two-wire link
`timescale 1ns/100ps
module bus_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  // ****************************************************************
  // Bit and byte level, 810 ns per bit when not stretched
  // ****************************************************************
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Bounded wait, the slave may stretch the low phase
  task automatic rise();
    scl_low <= 1'b0;
    #10;
    for (int i = 0; i < 400 && !scl; i++) #100;
  endtask : rise
  // Also used mid-frame, a repeated START keeps the bus
  task automatic start_cond();
    #200 sda_low <= 1'b0;
    #200 rise();
    #400 sda_low <= 1'b1;
    #400 scl_low <= 1'b1;
  endtask : start_cond
  task automatic stop_cond();
    #200 sda_low <= 1'b1;
    #200 rise();
    #400 sda_low <= 1'b0;
    #400;
  endtask : stop_cond
  task automatic bit_out(input logic b);
    #200 sda_low <= !b;
    #200 rise();
    #400 scl_low <= 1'b1;
  endtask : bit_out
  task automatic bit_in(output logic b);
    #200 sda_low <= 1'b0;
    #200 rise();
    #200 b = sda;
    #200 scl_low <= 1'b1;
  endtask : bit_in
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = !b;
  endtask : send_byte
  task automatic read_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(!ack);
  endtask : read_byte
endmodule : bus_master_model

//--- verif/twowire_slave_tx_status_tb.sv
// Self-checking bench for the slave-send status block
`timescale 1ns/100ps
module twowire_slave_tx_status_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic master_arb_lost = 1'b0;
  logic [7:0] reg_rdata;
  logic start_issued, scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
  int num_errors = 0;
  int total_checks = 0;
  logic ack;
  logic [7:0] d;
  // Pull-ups on both lines
  wire scl = (scl_oe ? scl_out : 1'b1) & !m_scl;
  wire sda = (sda_oe ? sda_out : 1'b1) & !m_sda;
  always #50 clock = !clock;
  twowire_slave_tx_status u_dut (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_arb_lost(master_arb_lost), .start_issued(start_issued),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  bus_master_model u_master (.scl(scl), .sda(sda), .scl_low(m_scl),
    .sda_low(m_sda));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string w, input logic [1:0] a, logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(w, e, reg_rdata);
  endtask : rd_chk
  task automatic address_read();
    u_master.start_cond();
    u_master.send_byte(8'hb5, ack);
    // Flag lags the pin by the synchroniser and the detector
    repeat (4) @(posedge clock);
    chk("addr ack", 8'h01, {7'h00, ack});
  endtask : address_read
  task automatic send_one(input logic [7:0] v, c, input logic a);
    wr(2'h1, v);
    wr(2'h2, c);
    u_master.read_byte(a, d);
    repeat (4) @(posedge clock);
    chk("byte", v, d);
  endtask : send_one
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_idle();
    rd_chk("status", 2'h0, twi_st_pkg::ST_NO_INFO);
    wr(2'h0, 8'h01);
    rd_chk("presc", 2'h0, 8'hf9);
    wr(2'h0, 8'h00);
    wr(2'h3, 8'hb4);
    wr(2'h2, 8'h44);
    $display("idle done");
  endtask : t_idle
  task automatic t_read();
    address_read();
    rd_chk("status", 2'h0, twi_st_pkg::ST_OWN_READ);
    chk("stretch", 8'h01, {7'h00, scl_oe});
    send_one(8'ha5, 8'hc4, 1'b1);
    rd_chk("status", 2'h0, twi_st_pkg::ST_DATA_ACK);
    send_one(8'h3c, 8'h84, 1'b0);
    rd_chk("status", 2'h0, twi_st_pkg::ST_DATA_NACK);
    wr(2'h2, 8'hc4);
    rd_chk("status", 2'h0, twi_st_pkg::ST_NO_INFO);
    u_master.stop_cond();
    $display("read done");
  endtask : t_read
  task automatic t_last();
    address_read();
    send_one(8'h81, 8'h84, 1'b1);
    rd_chk("status", 2'h0, twi_st_pkg::ST_LAST_ACK);
    wr(2'h2, 8'hc4);
    u_master.read_byte(1'b0, d);
    chk("ignored", 8'hff, d);
    u_master.stop_cond();
    $display("last done");
  endtask : t_last
  task automatic t_error();
    u_master.start_cond();
    repeat (3) u_master.bit_out(1'b1);
    u_master.start_cond();
    rd_chk("status", 2'h0, twi_st_pkg::ST_BUS_ERROR);
    chk("lines", 8'h00,
      {4'h0, scl_out, sda_out, scl_oe, sda_oe});
    u_master.stop_cond();
    wr(2'h2, 8'hd4);
    rd_chk("status", 2'h0, twi_st_pkg::ST_NO_INFO);
    rd_chk("control", 2'h2, 8'h44);
    $display("error done");
  endtask : t_error
  task automatic t_arb_begin();
    @(posedge clock);
    master_arb_lost <= 1'b1;
    @(posedge clock);
    master_arb_lost <= 1'b0;
    address_read();
    rd_chk("status", 2'h0, twi_st_pkg::ST_ARB_READ);
    send_one(8'h5e, 8'h84, 1'b0);
    wr(2'h2, 8'he4);
    u_master.stop_cond();
    for (int i = 0; i < 300 && start_issued !== 1'b1; i++) @(negedge clock);
    chk("start", 8'h01, {7'h00, start_issued});
    $display("arb done");
  endtask : t_arb_begin
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_idle();
    t_read();
    t_last();
    t_error();
    t_arb_begin();
    test_done();
  end
  // Hang guard, the run needs well under 4000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    test_done();
  end
endmodule : twowire_slave_tx_status_tb
